// ### design/urd_decode.v
// Purpose: Host register decode of an enhanced UART with 64-byte FIFOs
// Assumes: Host strobes are synchronous one-cycle pulses on clock
// Notes:   Serial engine, FIFOs and baud logic sit outside this block
`timescale 1ns/1ns
`include "urd_regs.vh"
`default_nettype none
module urd_decode #(
  parameter [7:0] REVISION = 8'h01, // Arbitrary value
  parameter [7:0] IDENT    = 8'h5a  // Arbitrary value
) (
  // Clock and reset
  input  wire       clock,
  input  wire       rstn,
  // Host bus
  input  wire [2:0] addr,
  input  wire [7:0] wdata,
  input  wire       wr_stb,
  input  wire       rd_stb,
  output reg  [7:0] rdata,
  // Serial engine side
  input  wire [7:0] rx_byte,
  input  wire [3:0] int_source,
  input  wire       int_xoff,
  input  wire       int_flow,
  input  wire [7:0] line_status,
  input  wire [7:0] modem_status,
  input  wire [7:0] fifo_level_count,
  output reg        rx_pop,
  output reg        tx_push,
  output reg  [7:0] tx_byte,
  output reg        rx_fifo_reset,
  output reg        tx_fifo_reset,
  output reg  [7:0] fifo_threshold,
  output reg        fifo_threshold_load,
  output wire [7:0] interrupt_enable_eff,
  output reg  [7:0] fifo_control,
  output reg  [7:0] line_control,
  output reg  [7:0] modem_control,
  output reg  [7:0] divisor_low,
  output reg  [7:0] divisor_high,
  output reg  [7:0] divisor_fraction,
  output reg  [7:0] feature_control,
  output reg  [7:0] enhanced_function,
  output reg  [7:0] modem_status_write,
  output reg  [7:0] enhanced_mode_select,
  output reg  [7:0] resume_char_one,
  output reg  [7:0] resume_char_two,
  output reg  [7:0] pause_char_one,
  output reg  [7:0] pause_char_two
);

  reg  [7:0] interrupt_enable;
  reg  [7:0] scratch_byte;
  reg  [7:0] next_rdata;
  wire       enh_set  = (line_control == `URD_ENH_SET);
  wire       dlab     = line_control[`URD_BIT_DLAB];
  wire       enh_on   = enhanced_function[`URD_BIT_ENH];
  wire       div_sel  = dlab && !enh_set;
  wire       div_zero = (divisor_low == `URD_DIV_ZERO) &&
                        (divisor_high == `URD_DIV_ZERO);
  wire       fsel     = feature_control[`URD_BIT_FSEL];
  // Pair open in either case per the enhanced bit
  wire       stat_sel = enh_on ? !dlab : !enh_set;
  wire       frac_sel = div_sel && enh_on;

  // Hidden enhanced bits read and act as zero
  assign interrupt_enable_eff = enh_on ? interrupt_enable :
                                {4'h0, interrupt_enable[3:0]};

  // Read mux; fraction wins over status when both selectable
  always @*
  begin
    next_rdata = 8'h00;
    case (addr)
      `URD_ADDR_DATA:
        if (enh_set)
          next_rdata = fifo_level_count;
        else if (div_sel)
          next_rdata = div_zero ? REVISION : divisor_low;
        else
          next_rdata = rx_byte;
      `URD_ADDR_IEN:
        if (enh_set)
          next_rdata = feature_control;
        else if (div_sel)
          next_rdata = div_zero ? IDENT : divisor_high;
        else
          next_rdata = interrupt_enable_eff;
      `URD_ADDR_ISTAT:
        if (frac_sel)
          next_rdata = divisor_fraction;
        else if (stat_sel)
          next_rdata = {fifo_control[0], fifo_control[0],
                        enh_on & int_flow, enh_on & int_xoff,
                        int_source};
        else if (enh_set)
          next_rdata = enhanced_function;
      `URD_ADDR_LCTL:
        next_rdata = line_control;
      `URD_ADDR_MCTL:
        next_rdata = enh_set ? resume_char_one : modem_control;
      `URD_ADDR_LSTAT:
        next_rdata = enh_set ? resume_char_two : line_status;
      `URD_ADDR_MSTAT:
        next_rdata = enh_set ? pause_char_one : modem_status;
      `URD_ADDR_SCR:
        if (enh_set)
          next_rdata = pause_char_two;
        else
          next_rdata = fsel ? fifo_level_count : scratch_byte;
      default:
        next_rdata = 8'h00;
    endcase
  end

  always @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      rdata                <= `URD_RST_BYTE;
      rx_pop               <= 1'b0;
      tx_push              <= 1'b0;
      tx_byte              <= `URD_RST_BYTE;
      rx_fifo_reset        <= 1'b0;
      tx_fifo_reset        <= 1'b0;
      fifo_threshold       <= `URD_RST_BYTE;
      fifo_threshold_load  <= 1'b0;
      interrupt_enable     <= `URD_RST_BYTE;
      fifo_control         <= `URD_RST_BYTE;
      line_control         <= `URD_RST_LCTL;
      modem_control        <= `URD_RST_BYTE;
      divisor_low          <= `URD_RST_BYTE;
      divisor_high         <= `URD_RST_BYTE;
      divisor_fraction     <= `URD_RST_BYTE;
      feature_control      <= `URD_RST_BYTE;
      enhanced_function    <= `URD_RST_BYTE;
      modem_status_write   <= `URD_RST_BYTE;
      enhanced_mode_select <= `URD_RST_BYTE;
      scratch_byte         <= `URD_RST_BYTE;
      resume_char_one      <= `URD_RST_BYTE;
      resume_char_two      <= `URD_RST_BYTE;
      pause_char_one       <= `URD_RST_BYTE;
      pause_char_two       <= `URD_RST_BYTE;
    end
    else
    begin
      // Pulses last one cycle
      rx_pop              <= 1'b0;
      tx_push             <= 1'b0;
      rx_fifo_reset       <= 1'b0;
      tx_fifo_reset       <= 1'b0;
      fifo_threshold_load <= 1'b0;
      if (rd_stb)
      begin
        rdata <= next_rdata;
        // Only a true data read consumes a receive byte
        if (addr == `URD_ADDR_DATA && !enh_set && !div_sel)
          rx_pop <= 1'b1;
      end
      if (wr_stb)
      begin
        case (addr)
          `URD_ADDR_DATA:
            if (enh_set)
            begin
              fifo_threshold      <= wdata;
              fifo_threshold_load <= 1'b1;
            end
            else if (div_sel)
              divisor_low <= wdata;
            else
            begin
              tx_byte <= wdata;
              tx_push <= 1'b1;
            end
          `URD_ADDR_IEN:
            if (enh_set)
              feature_control <= wdata;
            else if (div_sel)
              divisor_high <= wdata;
            else
              interrupt_enable <= wdata;
          `URD_ADDR_ISTAT:
            if (frac_sel)
              divisor_fraction <= wdata;
            else if (stat_sel)
            begin
              // Reset bits self-clear; never stored
              fifo_control  <= {wdata[7:3], 2'b00, wdata[0]};
              rx_fifo_reset <= wdata[1];
              tx_fifo_reset <= wdata[2];
            end
            else if (enh_set)
              enhanced_function <= wdata;
          `URD_ADDR_LCTL:
            line_control <= wdata;
          `URD_ADDR_MCTL:
            if (enh_set)
              resume_char_one <= wdata;
            else
              modem_control <= wdata;
          `URD_ADDR_LSTAT:
            if (enh_set)
              resume_char_two <= wdata;
          `URD_ADDR_MSTAT:
            if (enh_set)
              pause_char_one <= wdata;
            else if (enh_on)
              modem_status_write <= wdata;
          `URD_ADDR_SCR:
            if (enh_set)
              pause_char_two <= wdata;
            else if (fsel)
              enhanced_mode_select <= wdata;
            else
              scratch_byte <= wdata;
          default:
            scratch_byte <= scratch_byte;
        endcase
      end
    end
  end

endmodule // urd_decode
`default_nettype wire

// ### design/urd_regs.vh
// Purpose: Constants for the UART host register decode
// Assumes: Three address lines, eight-bit data
// Notes:   Offsets are register addresses on the parallel bus
`ifndef URD_REGS_VH
`define URD_REGS_VH
`define URD_ADDR_DATA      3'h0
`define URD_ADDR_IEN       3'h1
`define URD_ADDR_ISTAT     3'h2
`define URD_ADDR_LCTL      3'h3
`define URD_ADDR_MCTL      3'h4
`define URD_ADDR_LSTAT     3'h5
`define URD_ADDR_MSTAT     3'h6
`define URD_ADDR_SCR       3'h7
`define URD_ENH_SET        8'hbf
`define URD_DIV_ZERO       8'h00
`define URD_BIT_DLAB       7
`define URD_BIT_ENH        4
`define URD_BIT_FSEL       6
`define URD_RST_BYTE       8'h00
`define URD_RST_LCTL       8'h00
`define URD_RST_ISTAT_SRC  4'h1
`endif

// ### test/urd_engine_model.sv
// Purpose: Serial engine stand-in facing the register decode
// Assumes: Status inputs are steady levels
// Notes:   Receive byte advances on each pop
`timescale 1ns/1ns
`default_nettype none
module urd_engine_model (
  // Clock, reset and pop
  input  wire logic       clock,
  input  wire logic       rstn,
  input  wire logic       rx_pop,
  // Status toward the decode
  output wire logic [7:0] rx_byte,
  output wire logic [7:0] fifo_level_count,
  output wire logic [7:0] line_status,
  output wire logic [7:0] modem_status,
  output wire logic [3:0] int_source,
  output wire logic       int_xoff,
  output wire logic       int_flow
);
  logic [7:0] cnt;
  always @(posedge clock or negedge rstn)
    if (!rstn)
      cnt <= 8'h00;
    else if (rx_pop)
      cnt <= cnt + 8'h01;
  // Distinct values so a wrong mux leg shows up
  assign rx_byte = 8'ha0 + cnt;
  assign fifo_level_count = 8'h40 - cnt;
  assign line_status = 8'h61;
  assign modem_status = 8'hb0;
  assign int_source = 4'hc;
  assign int_xoff = 1'b1;
  assign int_flow = 1'b1;
endmodule // urd_engine_model
`default_nettype wire

// ### test/urd_decode_props.sv
// Purpose: Port-level checks of the register decode
// Assumes: One clock domain
// Notes:   Attached by bind below
`timescale 1ns/1ns
`default_nettype none
module urd_decode_props (
  input wire logic       clock, rstn, wr_stb, rd_stb,
  input wire logic       rx_pop, tx_push, rx_fifo_reset,
  input wire logic       fifo_threshold_load,
  input wire logic [2:0] addr,
  input wire logic [7:0] wdata, rdata, rx_byte, tx_byte,
  input wire logic [7:0] fifo_threshold, interrupt_enable_eff,
  input wire logic [7:0] line_control, divisor_low, enhanced_function
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  wire nrm = !line_control[7];
  property p_rd_lc;
    rd_stb && !wr_stb && addr == 3'h3 |=> rdata == line_control;
  endproperty
  property p_wr_lc;
    wr_stb && addr == 3'h3 |=> line_control == $past(wdata);
  endproperty
  property p_rx;
    rd_stb && addr == 3'h0 && nrm |=> rx_pop && rdata == $past(rx_byte);
  endproperty
  property p_tx;
    wr_stb && addr == 3'h0 && nrm |=> tx_push && tx_byte == $past(wdata);
  endproperty
  property p_eff;
    !enhanced_function[4] |-> interrupt_enable_eff[7:4] == 4'h0;
  endproperty
  property p_dll;
    wr_stb && addr == 3'h0 && !nrm && line_control != 8'hbf
      |=> divisor_low == $past(wdata);
  endproperty
  property p_fifo_threshold;
    wr_stb && addr == 3'h0 && line_control == 8'hbf
      |=> fifo_threshold_load && fifo_threshold == $past(wdata);
  endproperty
  property p_frst;
    wr_stb && addr == 3'h2 && nrm |=> rx_fifo_reset == $past(wdata[1]);
  endproperty
  a_rd_lc: assert property (p_rd_lc) else $error("lc read");
  a_wr_lc: assert property (p_wr_lc) else $error("lc write");
  a_rx: assert property (p_rx) else $error("rx read");
  a_tx: assert property (p_tx) else $error("tx write");
  a_eff: assert property (p_eff) else $error("ien mask");
  a_dll: assert property (p_dll) else $error("dll write");
  a_fifo_threshold: assert property (p_fifo_threshold) else $error("fifo_threshold");
  a_frst: assert property (p_frst) else $error("fifo reset");
  c_pop: cover property (rx_pop);
  c_fifo_threshold: cover property (fifo_threshold_load);
  c_rst: cover property (rx_fifo_reset);
endmodule // urd_decode_props
bind urd_decode urd_decode_props u_props (.*);
`default_nettype wire

// ### test/tb_top.sv
// Purpose: Self-checking bench for the register decode
// Assumes: Engine model on the status side
// Notes:   Host cycles are one-cycle strobes
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic clock = 0, rstn = 0, wr_stb = 0, rd_stb = 0;
  logic [2:0] addr = 0;
  logic [7:0] wdata = 0;
  int num_errors = 0, num_checks = 0;
  wire rx_pop, tx_push, rx_fifo_reset, tx_fifo_reset, int_xoff, int_flow;
  wire fifo_threshold_load;
  wire [3:0] int_source;
  wire [7:0] rdata, rx_byte, line_status, modem_status, fifo_level_count,
    tx_byte, fifo_threshold, interrupt_enable_eff, fifo_control,
    line_control, modem_control, divisor_low, divisor_high,
    divisor_fraction, feature_control, enhanced_function,
    modem_status_write, enhanced_mode_select, resume_char_one,
    resume_char_two, pause_char_one, pause_char_two;
  always #20 clock = ~clock;
  // Identity values are arbitrary
  urd_decode #(.REVISION(8'h3e), .IDENT(8'hc5)) dut (.*);
  urd_engine_model eng (.*);
  task wrap_up;
    $display("errors %0d checks %0d", num_errors, num_checks);
    if (num_errors == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task chk(input logic [7:0] s, e);
    num_checks++;
    if (s !== e)
    begin
      num_errors++;
      $display("mismatch %0t saw %h want %h", $time, s, e);
    end
  endtask
  task wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clock);
    wr_stb <= 1'b0;
    #1;
  endtask
  task rd(input logic [2:0] a, input logic [7:0] e);
    @(posedge clock);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clock);
    rd_stb <= 1'b0;
    #1;
    chk(rdata, e);
  endtask
  task t_normal;
    wr(3'h3, 8'h00);
    wr(3'h0, 8'h3c);
    chk(tx_byte, 8'h3c);
    rd(3'h0, 8'ha0);
    rd(3'h0, 8'ha1);
    wr(3'h4, 8'h5a);
    rd(3'h4, 8'h5a);
    wr(3'h7, 8'h99);
    rd(3'h7, 8'h99);
    rd(3'h5, 8'h61);
  endtask
  task t_divisor;
    wr(3'h3, 8'h83);
    rd(3'h0, 8'h3e);
    rd(3'h1, 8'hc5);
    wr(3'h0, 8'h12);
    wr(3'h1, 8'h34);
    rd(3'h0, 8'h12);
    rd(3'h1, 8'h34);
    rd(3'h3, 8'h83);
    wr(3'h2, 8'hc7);
    chk(fifo_control, 8'hc1);
    chk({7'h00, rx_fifo_reset}, 8'h01);
    chk({7'h00, tx_fifo_reset}, 8'h01);
    wr(3'h3, 8'h00);
    rd(3'h2, 8'hcc);
    wr(3'h1, 8'hff);
    chk(interrupt_enable_eff, 8'h0f);
  endtask
  task t_enhanced;
    wr(3'h3, 8'hbf);
    wr(3'h2, 8'h10);
    wr(3'h1, 8'h40);
    rd(3'h2, 8'h10);
    rd(3'h1, 8'h40);
    wr(3'h0, 8'h20);
    chk(fifo_threshold, 8'h20);
    rd(3'h0, 8'h3e);
    for (int i = 4; i < 8; i++)
      wr(3'(i), 8'(16 + i));
    chk(resume_char_one, 8'h14);
    chk(resume_char_two, 8'h15);
    chk(pause_char_one, 8'h16);
    chk(pause_char_two, 8'h17);
    wr(3'h3, 8'h00);
    rd(3'h2, 8'hfc);
    chk(interrupt_enable_eff, 8'hff);
    rd(3'h7, 8'h3e);
    wr(3'h7, 8'h0c);
    chk(enhanced_mode_select, 8'h0c);
    wr(3'h6, 8'h55);
    chk(modem_status_write, 8'h55);
    rd(3'h6, 8'hb0);
    wr(3'h3, 8'h80);
    wr(3'h2, 8'h77);
    chk(divisor_fraction, 8'h77);
    rd(3'h2, 8'h77);
  endtask
  initial
  begin
    repeat (6) @(posedge clock);
    rstn <= 1'b1;
    t_normal;
    t_divisor;
    t_enhanced;
    wrap_up;
  end
  // Whole run takes under ten microseconds
  initial
  begin
    #100000;
    num_errors++;
    wrap_up;
  end
endmodule // tb_top
`default_nettype wire
